// file: verilog/dic_pkg.sv
// constants, field layouts and carrier types of the input conditioner
// assumes a 100 MHz system clock and an AHB-Lite register port
package dic_pkg;

   ////////////////////////////////////////////////////////////////////////
   // timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int MS_NS         = 1000000;
   localparam int MS_CYCLES     = MS_NS / CLK_PERIOD_NS;
   localparam int WINDOW_MS     = 1000;
   localparam int REFRESH_MS    = 500;

   ////////////////////////////////////////////////////////////////////////
   // reset values and encodings
   localparam logic [15:0] FILT_RST    = 16'h0005;
   localparam logic [7:0]  OSC_LVL_RST = 8'h32;
   localparam logic [7:0]  OSC_HYS_RST = 8'h0a;
   localparam logic [1:0]  MODE_INPUT  = 2'h1;
   localparam logic [1:0]  MODE_COUNT  = 2'h2;
   localparam logic [31:0] TRIG_CLEAR  = 32'h0000_0000;
   localparam logic [31:0] TRIG_DIRTY  = 32'h0000_0001;
   localparam logic [31:0] TRIG_ALL    = 32'h0000_0002;

   ////////////////////////////////////////////////////////////////////////
   // register map, byte addresses
   localparam logic [11:0] GLB_OSC     = 12'h000;
   localparam logic [11:0] GLB_TRIG    = 12'h004;
   localparam logic [11:0] GLB_VALUE   = 12'h008;
   localparam logic [11:0] GLB_INVALID = 12'h00c;
   localparam logic [11:0] GLB_EVENT   = 12'h010;
   localparam logic [11:0] GLB_TIME    = 12'h014;
   localparam logic [2:0]  CH_REGION   = 3'h1;
   localparam logic [4:0]  CH_FILTER   = 5'h00;
   localparam logic [4:0]  CH_CONFIG   = 5'h04;
   localparam logic [4:0]  CH_PRESET   = 5'h08;
   localparam logic [4:0]  CH_COUNT    = 5'h0c;
   localparam logic [4:0]  CH_STAMP    = 5'h10;

   // field positions
   localparam int OSC_LVL_LSB  = 0;
   localparam int OSC_HYS_LSB  = 8;
   localparam int CFG_INV_BIT  = 0;
   localparam int CFG_MODE_LSB = 8;
   localparam int EV_REL_LSB   = 16;

   ////////////////////////////////////////////////////////////////////////
   // carriers
   typedef struct packed {
      logic        hsel;
      logic [11:0] haddr;
      logic [1:0]  htrans;
      logic        hwrite;
      logic [2:0]  hsize;
      logic [31:0] hwdata;
      logic        hready;
   } ahb_req_s;

   typedef struct packed {
      logic [31:0] hrdata;
      logic        hreadyout;
      logic        hresp;
   } ahb_rsp_s;

   typedef struct packed {
      logic [15:0] filt;
      logic        inv;
      logic [1:0]  mode;
      logic [30:0] preset;
      logic        dirty;
      logic [30:0] tally;
      logic [30:0] vis;
      logic        cand;
      logic        level;
      logic        status;
      logic        invalid;
      logic [7:0]  chg;
      logic [15:0] run;
      logic [31:0] pend;
      logic [31:0] stamp;
   } ch_s;

endpackage

// file: verilog/digital_input_conditioner.sv
// digital input conditioner: filter, polarity, pulse tally, chatter block
// assumes inputs already synchronous to REF_CLK and one AHB-Lite master
`timescale 1ns/10ps
module digital_input_conditioner #(
   parameter int             N_IN       = 15,
   parameter int             MS_CYC     = dic_pkg::MS_CYCLES,
   parameter logic [N_IN-1:0] CNT_CAPABLE = '1
) (
   // clock and reset
   input  wire logic             REF_CLK,
   input  wire logic             RESET_N,
   // register bus
   input  wire dic_pkg::ahb_req_s AHB_REQ,
   output      dic_pkg::ahb_rsp_s AHB_RSP,
   // field inputs
   input  wire logic [N_IN-1:0]  DIN_RAW,
   // conditioned state
   output      logic [N_IN-1:0]  DIN_STATUS,
   output      logic [N_IN-1:0]  INPUT_INVALID_FLAG
);

   localparam int DIV_W = $clog2(MS_CYC);

   typedef struct packed {
      logic [DIV_W-1:0]       div;
      logic [31:0]            ms_time;
      logic [9:0]             win;
      logic [8:0]             half;
      logic [7:0]             lvl;
      logic [7:0]             hys;
      logic [N_IN-1:0]        ev_blk;
      logic [N_IN-1:0]        ev_rel;
      logic                   dp_valid;
      logic                   dp_write;
      logic                   rd_ok;
      logic [11:0]            dp_addr;
      logic [31:0]            rdata;
      dic_pkg::ch_s [N_IN-1:0] ch;
   } st_s;

   st_s             st;
   st_s             next_st;
   logic            ms_tick;
   logic            sec_tick;
   logic            ref_tick;
   logic            wr;
   logic            wr_trig;
   logic [N_IN-1:0] rise;
   logic [31:0]     rd_val;

   // true when the word address falls on a register of channel idx
   function automatic logic ch_hit(input logic [11:0] a, input int idx);
      ch_hit = (a[11:9] == dic_pkg::CH_REGION) && (int'(a[8:5]) == idx);
   endfunction

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      logic       cand;
      logic       acc;
      logic [8:0] rel_sum;
      logic [4:0] sub;
      cand    = 1'b0;
      acc     = 1'b0;
      rel_sum = '0;
      sub     = '0;
      next_st = st;
      rise    = '0;
      rd_val  = '0;

      // millisecond timebase and its derived windows
      ms_tick  = (st.div == DIV_W'(MS_CYC - 1));
      sec_tick = ms_tick && (st.win == 10'(dic_pkg::WINDOW_MS - 1));
      ref_tick = ms_tick && (st.half == 9'(dic_pkg::REFRESH_MS - 1));
      next_st.div = ms_tick ? '0 : st.div + 1'b1;
      if (ms_tick) begin
         next_st.ms_time = st.ms_time + 32'h0000_0001;
         next_st.win  = sec_tick ? '0 : st.win + 1'b1;
         next_st.half = ref_tick ? '0 : st.half + 1'b1;
      end

      // bus data phase: writes take effect in their single data cycle
      wr      = st.dp_valid && st.dp_write;
      wr_trig = wr && (st.dp_addr == dic_pkg::GLB_TRIG);
      if (wr && st.dp_addr == dic_pkg::GLB_OSC) begin
         next_st.lvl = AHB_REQ.hwdata[dic_pkg::OSC_LVL_LSB +: 8];
         next_st.hys = AHB_REQ.hwdata[dic_pkg::OSC_HYS_LSB +: 8];
      end
      // write one to clear; hardware sets below win over the clear
      if (wr && st.dp_addr == dic_pkg::GLB_EVENT) begin
         next_st.ev_blk = st.ev_blk & ~AHB_REQ.hwdata[N_IN-1:0];
         next_st.ev_rel = st.ev_rel
                        & ~AHB_REQ.hwdata[dic_pkg::EV_REL_LSB +: N_IN];
      end

      for (int i = 0; i < N_IN; i++) begin
         // polarity applied ahead of the filter
         cand = DIN_RAW[i] ^ st.ch[i].inv;
         acc  = 1'b0;
         next_st.ch[i].cand = cand;
         if (cand == st.ch[i].level) begin
            next_st.ch[i].run = '0;
         end else if (st.ch[i].cand == st.ch[i].level) begin
            // raw edge: remember its time for the stamp
            next_st.ch[i].pend = st.ms_time;
            next_st.ch[i].run  = '0;
         end else if (ms_tick) begin
            // accept only after more than the filter time
            if (st.ch[i].run >= st.ch[i].filt) begin
               acc = 1'b1;
            end else begin
               next_st.ch[i].run = st.ch[i].run + 16'h0001;
            end
         end
         if (acc) begin
            next_st.ch[i].level = cand;
            next_st.ch[i].stamp = st.ch[i].pend;
            next_st.ch[i].run   = '0;
            if (st.ch[i].chg != 8'hff) begin
               next_st.ch[i].chg = st.ch[i].chg + 8'h01;
            end
            // a blocked input keeps its frozen status
            if (!st.ch[i].invalid) begin
               next_st.ch[i].status = cand;
            end
            rise[i] = cand;
         end
         // tally counts filtered rising edges only when counting
         // 31 bits wrap to zero past the top
         if (st.ch[i].mode == dic_pkg::MODE_COUNT && rise[i]) begin
            next_st.ch[i].tally = st.ch[i].tally + 31'h0000_0001;
         end
         // chatter window closes once a second
         if (sec_tick) begin
            rel_sum = {1'b0, next_st.ch[i].chg} + {1'b0, st.hys};
            if (next_st.ch[i].chg > st.lvl) begin
               next_st.ch[i].invalid = 1'b1;
               if (!st.ch[i].invalid) begin
                  next_st.ev_blk[i] = 1'b1;
               end
            end else if (st.ch[i].invalid && rel_sum < {1'b0, st.lvl}) begin
               next_st.ch[i].invalid = 1'b0;
               next_st.ch[i].status  = next_st.ch[i].level;
               next_st.ev_rel[i]     = 1'b1;
            end
            next_st.ch[i].chg = '0;
         end
         // visible tally follows the running one only at refresh and on load commands
         if (ref_tick) begin
            next_st.ch[i].vis = next_st.ch[i].tally;
         end
         // load commands act on tally and visible copy at once
         if (wr_trig) begin
            unique case (AHB_REQ.hwdata)
               dic_pkg::TRIG_CLEAR: begin
                  next_st.ch[i].tally = '0;
                  next_st.ch[i].vis   = '0;
               end
               dic_pkg::TRIG_DIRTY: begin
                  if (st.ch[i].dirty) begin
                     next_st.ch[i].tally = st.ch[i].preset;
                     next_st.ch[i].vis   = st.ch[i].preset;
                     next_st.ch[i].dirty = 1'b0;
                  end
               end
               dic_pkg::TRIG_ALL: begin
                  next_st.ch[i].tally = st.ch[i].preset;
                  next_st.ch[i].vis   = st.ch[i].preset;
                  next_st.ch[i].dirty = 1'b0;
               end
               default: begin
               end
            endcase
         end
         // channel settings
         if (wr && ch_hit(st.dp_addr, i)) begin
            unique case (st.dp_addr[4:0])
               dic_pkg::CH_FILTER: begin
                  next_st.ch[i].filt = AHB_REQ.hwdata[15:0];
               end
               dic_pkg::CH_CONFIG: begin
                  next_st.ch[i].inv = AHB_REQ.hwdata[dic_pkg::CFG_INV_BIT];
                  // only capable inputs may count; other codes are ignored
                  if (AHB_REQ.hwdata[dic_pkg::CFG_MODE_LSB +: 2]
                        == dic_pkg::MODE_INPUT
                      || (CNT_CAPABLE[i]
                          && AHB_REQ.hwdata[dic_pkg::CFG_MODE_LSB +: 2]
                             == dic_pkg::MODE_COUNT)) begin
                     next_st.ch[i].mode =
                        AHB_REQ.hwdata[dic_pkg::CFG_MODE_LSB +: 2];
                  end
               end
               dic_pkg::CH_PRESET: begin
                  next_st.ch[i].preset = AHB_REQ.hwdata[30:0];
                  next_st.ch[i].dirty  = 1'b1;
               end
               default: begin
               end
            endcase
         end
         // read decode
         if (ch_hit(st.dp_addr, i)) begin
            sub = st.dp_addr[4:0];
            unique case (sub)
               dic_pkg::CH_FILTER: rd_val = {16'h0000, st.ch[i].filt};
               dic_pkg::CH_CONFIG: begin
                  rd_val = '0;
                  rd_val[dic_pkg::CFG_INV_BIT] = st.ch[i].inv;
                  rd_val[dic_pkg::CFG_MODE_LSB +: 2] = st.ch[i].mode;
               end
               dic_pkg::CH_PRESET: rd_val = {1'b0, st.ch[i].preset};
               dic_pkg::CH_COUNT:  rd_val = {1'b0, st.ch[i].vis};
               dic_pkg::CH_STAMP:  rd_val = st.ch[i].stamp;
               default:            rd_val = '0;
            endcase
         end
      end

      unique case (st.dp_addr)
         dic_pkg::GLB_OSC:     rd_val = {16'h0000, st.hys, st.lvl};
         dic_pkg::GLB_VALUE:   rd_val = 32'(DIN_STATUS);
         dic_pkg::GLB_INVALID: rd_val = 32'(INPUT_INVALID_FLAG);
         dic_pkg::GLB_EVENT: begin
            rd_val = 32'(st.ev_blk);
            rd_val[dic_pkg::EV_REL_LSB +: N_IN] = st.ev_rel;
         end
         dic_pkg::GLB_TIME:    rd_val = st.ms_time;
         default: begin
         end
      endcase

      // reads take one wait cycle so that read data comes from a flop
      if (st.dp_valid && !st.dp_write && !st.rd_ok) begin
         next_st.rdata = rd_val;
         next_st.rd_ok = 1'b1;
      end
      if (AHB_REQ.hready) begin
         next_st.dp_valid = AHB_REQ.hsel && AHB_REQ.htrans[1];
         next_st.dp_write = AHB_REQ.hwrite;
         next_st.dp_addr  = {AHB_REQ.haddr[11:2], 2'b00};
         next_st.rd_ok    = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // defaults after reset
   always_ff @(posedge REF_CLK) begin
      if (!RESET_N) begin
         st     <= '0;
         st.lvl <= dic_pkg::OSC_LVL_RST;
         st.hys <= dic_pkg::OSC_HYS_RST;
         for (int i = 0; i < N_IN; i++) begin
            st.ch[i].filt <= dic_pkg::FILT_RST;
            st.ch[i].mode <= dic_pkg::MODE_INPUT;
         end
      end else begin
         st <= next_st;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      AHB_RSP.hrdata    = st.rdata;
      AHB_RSP.hreadyout = !(st.dp_valid && !st.dp_write && !st.rd_ok);
      AHB_RSP.hresp     = 1'b0;
      for (int i = 0; i < N_IN; i++) begin
         DIN_STATUS[i]         = st.ch[i].status;
         INPUT_INVALID_FLAG[i] = st.ch[i].invalid;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (!RESET_N);

   AST_MS_TICK: assert property (
      ms_tick |=> st.div == '0 ##1 st.div == DIV_W'(1)
   ) else $error("millisecond divider did not restart");

   for (genvar g = 0; g < N_IN; g++) begin : g_chk
      AST_FILTER: assert property (
         st.ch[g].level != $past(st.ch[g].level)
         |-> $past(ms_tick) && $past(st.ch[g].run) >= $past(st.ch[g].filt)
      ) else $error("filtered level changed before filter time");

      AST_STAMP: assert property (
         $changed(st.ch[g].level) |-> st.ch[g].stamp == $past(st.ch[g].pend)
      ) else $error("stamp is not the time of the raw change");

      AST_POLARITY: assert property (
         ##1 st.ch[g].cand == ($past(DIN_RAW[g]) ^ $past(st.ch[g].inv))
      ) else $error("polarity not applied to input");

      AST_HOLD: assert property (
         st.ch[g].mode == dic_pkg::MODE_INPUT && !wr_trig
         |=> $stable(st.ch[g].tally)
      ) else $error("tally moved in plain input operation");

      AST_COUNT: assert property (
         st.ch[g].mode == dic_pkg::MODE_COUNT && rise[g] && !wr_trig
         |=> st.ch[g].tally == $past(st.ch[g].tally) + 31'h0000_0001
      ) else $error("counted edge not added to tally");

      AST_REFRESH: assert property (
         !ref_tick && !wr_trig |=> $stable(st.ch[g].vis)
      ) else $error("visible tally changed outside refresh");

      AST_CLEAR: assert property (
         wr_trig && AHB_REQ.hwdata == dic_pkg::TRIG_CLEAR
         |=> st.ch[g].tally == '0 && st.ch[g].vis == '0
      ) else $error("clear command left a tally");

      AST_LOAD_ALL: assert property (
         wr_trig && AHB_REQ.hwdata == dic_pkg::TRIG_ALL
         |=> st.ch[g].tally == $past(st.ch[g].preset) && !st.ch[g].dirty
      ) else $error("load-all did not copy start value");

      AST_BLOCK: assert property (
         sec_tick && st.ch[g].chg > st.lvl && !rise[g]
         |=> st.ch[g].invalid && (st.ev_blk[g] || $past(st.ch[g].invalid))
      ) else $error("chattering input not blocked");

      AST_FROZEN: assert property (
         st.ch[g].invalid ##1 st.ch[g].invalid |-> $stable(DIN_STATUS[g])
      ) else $error("blocked input status moved");
   end

endmodule

// file: bench/field_contacts.sv
// field contact model: steady levels plus a timed train of toggles
// assumes the bench starts a train with a one-cycle go pulse
`timescale 1ns/10ps
module field_contacts (
   // clock
   input  wire logic        clk,
   // commands from the bench
   input  wire logic [14:0] level,
   input  wire logic [14:0] tog_mask,
   input  wire logic [31:0] half,
   input  wire logic [31:0] toggles,
   input  wire logic        go,
   // contact levels seen through the optocouplers, and a train busy flag
   output      logic [14:0] din,
   output      logic        busy
);
   int          left = 0;
   int          cnt  = 0;
   logic [14:0] flip = 15'h0;

   ////////////////////////////////////////////////////////////////////////
   // a go with zero toggles stops a running train where it stands
   always @(posedge clk) begin
      if (go) begin
         left <= toggles;
         cnt  <= half;
      end else if (left > 0) begin
         if (cnt <= 1) begin
            flip <= flip ^ tog_mask;
            left <= left - 1;
            cnt  <= half;
         end else begin
            cnt <= cnt - 1;
         end
      end
   end

   assign din  = level ^ flip;
   assign busy = (left > 0) || go;
endmodule

// file: bench/tb_digital_input_conditioner.sv
// self-checking bench for the digital input conditioner
// assumes the field contact model and the package register map
`timescale 1ns/10ps
module tb_digital_input_conditioner;
   // short millisecond keeps one-second windows affordable
   localparam int MS = 10;
   logic              clk;
   logic              rst_n;
   dic_pkg::ahb_req_s req;
   dic_pkg::ahb_req_s bus;
   dic_pkg::ahb_rsp_s rsp;
   logic [14:0]       raw;
   logic [14:0]       status;
   logic [14:0]       inv_flag;
   logic [14:0]       level;
   logic [14:0]       tmask;
   int                half;
   int                toggles;
   logic              go;
   logic              busy;
   int                err_count;
   int                comparisons;
   int                tally[16];
   int                preset[16];
   bit                dirty[16];
   logic [31:0]       rd;
   logic [31:0]       t0;
   int                n;

   always_comb begin
      bus        = req;
      bus.hready = rsp.hreadyout;
   end

   digital_input_conditioner #(.MS_CYC(MS)) i_digital_input_conditioner (
      .REF_CLK(clk), .RESET_N(rst_n), .AHB_REQ(bus), .AHB_RSP(rsp),
      .DIN_RAW(raw), .DIN_STATUS(status), .INPUT_INVALID_FLAG(inv_flag));

   field_contacts i_field_contacts (.clk(clk), .level(level),
      .tog_mask(tmask), .half(half), .toggles(toggles), .go(go),
      .din(raw), .busy(busy));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_count++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic close_out;
      $display("comparisons %0d, mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task automatic wait_ms(input int k);
      repeat (k * MS) @(posedge clk);
   endtask

   // waits for hready sampled high at a rising edge, bounded
   task automatic wait_rdy;
      int k;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (rsp.hreadyout !== 1'b1 && k < 50);
      if (k >= 50) check(32'h0, 32'h1);
   endtask

   task automatic xfer(input logic wr, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] q);
      req.hsel   <= 1'b1;
      req.haddr  <= a;
      req.htrans <= 2'b10;
      req.hwrite <= wr;
      wait_rdy();
      req.htrans <= 2'b00;
      req.hwdata <= wr ? d : 32'h0;
      wait_rdy();
      q = rsp.hrdata;
      check(rsp.hresp, 1'b0);
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] q;
      xfer(1'b1, a, d, q);
   endtask

   task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
      xfer(1'b0, a, 32'h0, rd);
      check(rd, e);
   endtask

   function automatic logic [11:0] ch(input int i, input logic [4:0] off);
      return 12'h200 + 12'(i * 32) + {7'h0, off};
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // reference tallies: a load writes the running and visible value at once
   task automatic trig(input int code);
      wr(dic_pkg::GLB_TRIG, 32'(code));
      for (int i = 0; i < 15; i++) begin
         if (code == 0)
            tally[i] = 0;
         else if (code == 2 || (code == 1 && dirty[i]))
            tally[i] = preset[i];
         if (code == 1 || code == 2)
            dirty[i] = 1'b0;
      end
   endtask

   task automatic cmp_tally;
      for (int i = 2; i < 5; i++)
         rd_chk(ch(i, dic_pkg::CH_COUNT), 32'(tally[i]));
   endtask

   initial begin
      repeat (70000) @(posedge clk);
      err_count++;
      $display("mismatch at %0t: watchdog expired", $time);
      close_out();
   end

   ////////////////////////////////////////////////////////////////////////
   initial begin
      req       = '0;
      req.hsize = 3'h2;
      rst_n     = 1'b0;
      level     = 15'h0;
      tmask     = 15'h0;
      half      = 1;
      toggles   = 0;
      go        = 1'b0;
      err_count = 0;
      comparisons = 0;
      for (int i = 0; i < 16; i++) begin
         tally[i]  = 0;
         preset[i] = 0;
         dirty[i]  = 1'b0;
      end
      void'($urandom(32'hc5e8f38d));
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      rd_chk(dic_pkg::GLB_OSC, 32'h0000_0a32);
      rd_chk(dic_pkg::GLB_INVALID, 32'h0);
      rd_chk(ch(0, dic_pkg::CH_FILTER), 32'h5);
      rd_chk(ch(2, dic_pkg::CH_CONFIG), 32'h100);
      rd_chk(ch(2, dic_pkg::CH_PRESET), 32'h0);
      rd_chk(ch(2, dic_pkg::CH_COUNT), 32'h0);
      rd_chk(12'h100, 32'h0);
      $display("test reset values done");
      // a glitch shorter than the filter time is dropped
      level[0] <= 1'b1;
      wait_ms(4);
      level[0] <= 1'b0;
      wait_ms(10);
      check(status, 32'h0);
      xfer(1'b0, dic_pkg::GLB_TIME, 32'h0, t0);
      level[0] <= 1'b1;
      wait_ms(5);
      check(status[0], 1'b0);
      wait_ms(3);
      check(status[0], 1'b1);
      xfer(1'b0, ch(0, dic_pkg::CH_STAMP), 32'h0, rd);
      check(rd == t0 || rd == t0 + 1, 1'b1);
      $display("test filter and stamp done");
      wr(ch(1, dic_pkg::CH_FILTER), 32'h1);
      wr(ch(1, dic_pkg::CH_CONFIG), 32'h101);
      wait_ms(5);
      check(status[1], 1'b1);
      level[1] <= 1'b1;
      wait_ms(5);
      check(status[1], 1'b0);
      rd_chk(dic_pkg::GLB_VALUE, 32'h1);
      $display("test polarity done");
      preset[2] = 32'h7fff_fffc + ($urandom % 3);
      preset[3] = $urandom & 32'h7fff_ffff;
      preset[4] = $urandom & 32'h7fff_ffff;
      for (int i = 2; i < 5; i++) begin
         wr(ch(i, dic_pkg::CH_PRESET), 32'(preset[i]));
         dirty[i] = 1'b1;
      end
      cmp_tally();
      trig(1);
      cmp_tally();
      trig(0);
      cmp_tally();
      wr(ch(4, dic_pkg::CH_PRESET), 32'(preset[4]));
      dirty[4] = 1'b1;
      trig(1);
      cmp_tally();
      wr(dic_pkg::GLB_TRIG, 32'h3);
      cmp_tally();
      trig(2);
      cmp_tally();
      $display("test load commands done");
      wr(ch(2, dic_pkg::CH_CONFIG), 32'h200);
      wr(ch(3, dic_pkg::CH_CONFIG), 32'h300);
      rd_chk(ch(3, dic_pkg::CH_CONFIG), 32'h100);
      wr(ch(2, dic_pkg::CH_FILTER), 32'h1);
      wr(ch(3, dic_pkg::CH_FILTER), 32'h1);
      // 100 Hz train on a counting and a plain input together
      n = 3 + int'($urandom % 4);
      half    <= 5 * MS;
      toggles <= 2 * n;
      tmask   <= 15'h000c;
      go      <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      for (int k = 0; k < n; k++)
         tally[2] = (tally[2] + 1) & 32'h7fff_ffff;
      wait_ms(10 * n + 510);
      check(busy, 1'b0);
      cmp_tally();
      $display("test pulse counting done");
      wr(dic_pkg::GLB_OSC, 32'h0000_0528);
      rd_chk(dic_pkg::GLB_OSC, 32'h0000_0528);
      wr(ch(5, dic_pkg::CH_FILTER), 32'h1);
      half    <= 4 * MS;
      toggles <= 600;
      tmask   <= 15'h0020;
      go      <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      n = 0;
      while (inv_flag[5] !== 1'b1 && n < 2200 * MS) begin
         @(posedge clk);
         n++;
      end
      check(inv_flag[5], 1'b1);
      t0 = {31'h0, status[5]};
      toggles <= 0;
      go      <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      wait_ms(20);
      check(status[5], t0[0]);
      n = 0;
      while (inv_flag[5] !== 1'b0 && n < 1100 * MS) begin
         @(posedge clk);
         n++;
      end
      check(inv_flag[5], 1'b0);
      wait_ms(2);
      check(status[5], raw[5]);
      rd_chk(dic_pkg::GLB_EVENT, 32'h0020_0020);
      wr(dic_pkg::GLB_EVENT, 32'h0020_0020);
      rd_chk(dic_pkg::GLB_EVENT, 32'h0);
      $display("test chatter block done");
      close_out();
   end
endmodule
